/* synth_pkg.sv */
// constants, field layout and presets for the synthesizer digital core
// assumes a 25 MHz crystal clock and a single serial-write port
// What this block does
// - reference divider divides crystal by R 4..1023
// - feedback uses prescaler, 4-bit and 13-bit counters
// - prescaler 17 until swallow ends, then 16
// - ratio bits 0-3 swallow, 4-16 program counter
// - swallow 0..15, program 4..8191, ratio 64..131071
// - separate rx and tx settings, mode selects pair
// - serial writes in programmable mode, presets standalone
// - lock drives shared pin only in programmable mode
// - qualify counter counts only while pulses overlap
// - threshold sets counts needed before lock
// - unlock reloads qualify counter, drops lock if latch select 1
// - watch counter reloads on overlap, else decrements
// - tolerance sets clocks without overlap before unlock
// - latch select 0 holds lock for active mode
// - programmable detector polarity setting
// - programmable charge pump current setting
// - oscillator current limits; equal disables regulation
// - first select-pin change enters programmable mode
// - idle mode keeps last rx or tx settings
package synth_pkg;
  localparam int FRAME_W = 24;
  localparam int ADDR_HI = 23;
  localparam int ADDR_LO = 21;
  localparam logic [2:0] A_RX_REF = 3'h0;
  localparam logic [2:0] A_RX_FB  = 3'h1;
  localparam logic [2:0] A_TX_REF = 3'h2;
  localparam logic [2:0] A_TX_FB  = 3'h3;
  localparam logic [2:0] A_CFG    = 3'h4;
  localparam logic [2:0] A_LOCK   = 3'h5;
  // config and lock word fields
  localparam int F_OPM    = 0;
  localparam int F_LATCH  = 2;
  localparam int F_POL    = 3;
  localparam int F_PUMP   = 4;
  localparam int F_VCO    = 6;
  localparam int F_OSC_STARTUP_CURRENT  = 8;
  localparam int F_OSC_STEADY_CURRENT  = 12;
  localparam int F_THR    = 0;
  localparam int F_TOL    = 8;
  localparam int SWAL_W   = 4;
  // reset values double as standalone presets
  localparam logic [9:0]  RX_REF_RST = 10'h020;
  localparam logic [16:0] RX_FB_RST  = 17'h00d8c;
  localparam logic [9:0]  TX_REF_RST = 10'h020;
  localparam logic [16:0] TX_FB_RST  = 17'h00e4c;
  localparam logic [9:0]  R_MIN      = 10'h004;
  localparam logic [1:0]  PUMP_RST   = 2'h3;
  localparam logic [1:0]  VCO_RST    = 2'h1;
  localparam logic [3:0]  OSC_STARTUP_CURRENT_RST  = 4'hc;
  localparam logic [3:0]  OSC_STEADY_CURRENT_RST  = 4'h4;
  localparam logic [7:0]  THR_RST    = 8'h10;
  localparam logic [7:0]  TOL_RST    = 8'h08;
  localparam logic [4:0]  PRE_LAST17 = 5'h10;
  localparam logic [4:0]  PRE_LAST16 = 5'h0f;
  typedef enum logic [3:0] {
    M_OFF  = 4'b0001,
    M_RX   = 4'b0010,
    M_TX   = 4'b0100,
    M_IDLE = 4'b1000
  } mode_t;
endpackage : synth_pkg

/* synth_core.sv */
// divider chain, lock detector, mode and serial settings of the synthesizer
// assumes all pins sampled on clk_i; vco_i pulses once per vco period
`timescale 1ns/1ps
module synth_core (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       re_sclk_i,
  input  wire logic       te_sdta_i,
  input  wire logic       freqsel0_serial_enable_pin_i,
  input  wire logic       freqsel1_lock_pin_i,
  input  wire logic       vco_i,
  input  wire logic       up_i,
  input  wire logic       dn_i,
  output logic            freqsel1_lock_pin_o,
  output logic            freqsel1_lock_pin_oe_o,
  output logic            ref_pulse_o,
  output logic            fb_pulse_o,
  output logic            rx_o,
  output logic            tx_o,
  output logic            programmable_mode_o,
  output logic            detector_polarity_o,
  output logic [1:0]      pump_current_o,
  output logic [1:0]      oscillator_current_o,
  output logic [3:0]      osc_startup_current_o,
  output logic [3:0]      osc_steady_current_o,
  output logic            amp_reg_en_o
);
  typedef struct packed {
    synth_pkg::mode_t mode;
    logic        last_tx;
    logic        armed;
    logic        sden0;
    logic        programmable_mode;
    logic        sclk_q;
    logic        sden_q;
    logic [23:0] sh;
    logic [4:0]  bits;
    logic [9:0]  rx_ref;
    logic [16:0] rx_fb;
    logic [9:0]  tx_ref;
    logic [16:0] tx_fb;
    logic [1:0]  opm;
    logic        latch_sel;
    logic        pol;
    logic [1:0]  pump;
    logic [1:0]  oscillator_current_setting;
    logic [3:0]  osc_startup_current;
    logic [3:0]  osc_steady_current;
    logic [7:0]  thr;
    logic [7:0]  tol;
    logic [9:0]  r_cnt;
    logic [4:0]  pre;
    logic [3:0]  a_cnt;
    logic [12:0] b_cnt;
    logic [7:0]  qual;
    logic [7:0]  watch;
    logic        lock;
    logic        ref_p;
    logic        fb_p;
    logic        amp_en;
    logic        ld_pin;
  } state_t;

  state_t st_reg;
  state_t st_next;
  logic        pum_now;
  logic        enter;
  logic        use_tx;
  logic        running;
  logic        overlap;
  logic        unlock;
  logic [9:0]  r_sel;
  logic [16:0] n_sel;
  logic [1:0]  opm_now;
  logic [20:0] wdata;

  ////////////////////////////////////////////////////////////////////
  always_comb begin
    st_next = st_reg;
    // any level change after reset release counts as the switch
    pum_now = st_reg.programmable_mode | (st_reg.armed & (freqsel0_serial_enable_pin_i != st_reg.sden0));
    st_next.armed = 1'b1;
    if (!st_reg.armed) begin
      st_next.sden0 = freqsel0_serial_enable_pin_i;
    end
    st_next.programmable_mode = pum_now;
    st_next.sclk_q = re_sclk_i;
    st_next.sden_q = freqsel0_serial_enable_pin_i;
    wdata = st_reg.sh[20:0];

    // serial shift, msb first, committed on falling enable
    if (pum_now && freqsel0_serial_enable_pin_i) begin
      if (re_sclk_i && !st_reg.sclk_q) begin
        st_next.sh = {st_reg.sh[22:0], te_sdta_i};
        st_next.bits = st_reg.bits + 5'h01;
      end
    end else begin
      st_next.bits = 5'h00;
    end
    // short or long frames are dropped whole
    if (st_reg.programmable_mode && st_reg.sden_q && !freqsel0_serial_enable_pin_i
        && st_reg.bits == 5'(synth_pkg::FRAME_W)) begin
      case (st_reg.sh[synth_pkg::ADDR_HI:synth_pkg::ADDR_LO])
        synth_pkg::A_RX_REF: st_next.rx_ref = wdata[9:0];
        synth_pkg::A_RX_FB:  st_next.rx_fb = wdata[16:0];
        synth_pkg::A_TX_REF: st_next.tx_ref = wdata[9:0];
        synth_pkg::A_TX_FB:  st_next.tx_fb = wdata[16:0];
        synth_pkg::A_CFG: begin
          st_next.opm = wdata[synth_pkg::F_OPM +: 2];
          st_next.latch_sel = wdata[synth_pkg::F_LATCH];
          st_next.pol = wdata[synth_pkg::F_POL];
          st_next.pump = wdata[synth_pkg::F_PUMP +: 2];
          st_next.oscillator_current_setting = wdata[synth_pkg::F_VCO +: 2];
          st_next.osc_startup_current = wdata[synth_pkg::F_OSC_STARTUP_CURRENT +: 4];
          st_next.osc_steady_current = wdata[synth_pkg::F_OSC_STEADY_CURRENT +: 4];
        end
        synth_pkg::A_LOCK: begin
          st_next.thr = wdata[synth_pkg::F_THR +: 8];
          st_next.tol = wdata[synth_pkg::F_TOL +: 8];
        end
        default: ;
      endcase
    end
    st_next.amp_en = (st_next.osc_startup_current != st_next.osc_steady_current);

    ////////////////////////////////////////////////////////////////////
    // mode select: pins in standalone, config word otherwise
    opm_now = pum_now ? st_reg.opm : {te_sdta_i, re_sclk_i};
    case (opm_now)
      2'h1: st_next.mode = synth_pkg::M_RX;
      2'h2: st_next.mode = synth_pkg::M_TX;
      2'h3: st_next.mode = synth_pkg::M_IDLE;
      default: st_next.mode = synth_pkg::M_OFF;
    endcase
    if (st_reg.mode == synth_pkg::M_RX) begin
      st_next.last_tx = 1'b0;
    end
    if (st_reg.mode == synth_pkg::M_TX) begin
      st_next.last_tx = 1'b1;
    end
    use_tx = (st_reg.mode == synth_pkg::M_TX)
           | ((st_reg.mode == synth_pkg::M_IDLE) & st_reg.last_tx);
    running = (st_reg.mode != synth_pkg::M_OFF);
    r_sel = use_tx ? st_reg.tx_ref : st_reg.rx_ref;
    n_sel = use_tx ? st_reg.tx_fb : st_reg.rx_fb;
    if (r_sel < synth_pkg::R_MIN) begin
      r_sel = synth_pkg::R_MIN;
    end

    ////////////////////////////////////////////////////////////////////
    // reference divider, reload on wrap or while off
    st_next.ref_p = 1'b0;
    if (!running) begin
      st_next.r_cnt = r_sel - 10'h001;
    end else if (st_reg.r_cnt == 10'h000) begin
      st_next.r_cnt = r_sel - 10'h001;
      st_next.ref_p = 1'b1;
    end else begin
      st_next.r_cnt = st_reg.r_cnt - 10'h001;
    end

    // pulse swallow feedback divider
    st_next.fb_p = 1'b0;
    if (!running) begin
      st_next.pre = 5'h00;
      st_next.a_cnt = n_sel[3:0];
      st_next.b_cnt = n_sel[16:4];
    end else if (vco_i) begin
      if ((st_reg.a_cnt != 4'h0 && st_reg.pre == synth_pkg::PRE_LAST17)
          || (st_reg.a_cnt == 4'h0 && st_reg.pre == synth_pkg::PRE_LAST16)) begin
        st_next.pre = 5'h00;
        if (st_reg.b_cnt <= 13'h0001) begin
          st_next.fb_p = 1'b1;
          st_next.a_cnt = n_sel[synth_pkg::SWAL_W-1:0];
          st_next.b_cnt = n_sel[16:synth_pkg::SWAL_W];
        end else begin
          st_next.b_cnt = st_reg.b_cnt - 13'h0001;
          if (st_reg.a_cnt != 4'h0) begin
            st_next.a_cnt = st_reg.a_cnt - 4'h1;
          end
        end
      end else begin
        st_next.pre = st_reg.pre + 5'h01;
      end
    end

    ////////////////////////////////////////////////////////////////////
    // lock detector
    enter = (st_next.mode == synth_pkg::M_RX || st_next.mode == synth_pkg::M_TX)
          && (st_reg.mode != st_next.mode);
    overlap = up_i & dn_i;
    unlock = (st_reg.watch == 8'h00);
    if (enter) begin
      st_next.qual = st_reg.thr;
      st_next.watch = st_reg.tol;
    end else begin
      if (overlap) begin
        st_next.watch = st_reg.tol;
      end else if (st_reg.watch != 8'h00) begin
        st_next.watch = st_reg.watch - 8'h01;
      end
      if (unlock) begin
        st_next.qual = st_reg.thr;
      end else if (overlap && st_reg.qual != 8'h00) begin
        st_next.qual = st_reg.qual - 8'h01;
      end
    end
    // lock only lives during receive or transmit
    if (enter || !(st_next.mode == synth_pkg::M_RX || st_next.mode == synth_pkg::M_TX)) begin
      st_next.lock = 1'b0;
    end else if (unlock) begin
      st_next.lock = st_reg.lock & !st_reg.latch_sel;
    end else if (st_reg.qual == 8'h00) begin
      st_next.lock = 1'b1;
    end
    // pin copy kept in its own flop so the output needs no gate
    st_next.ld_pin = st_next.lock & st_next.programmable_mode;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_reg <= '{mode: synth_pkg::M_OFF, rx_ref: synth_pkg::RX_REF_RST,
                  rx_fb: synth_pkg::RX_FB_RST, tx_ref: synth_pkg::TX_REF_RST,
                  tx_fb: synth_pkg::TX_FB_RST, pump: synth_pkg::PUMP_RST,
                  oscillator_current_setting: synth_pkg::VCO_RST, osc_startup_current: synth_pkg::OSC_STARTUP_CURRENT_RST,
                  osc_steady_current: synth_pkg::OSC_STEADY_CURRENT_RST, thr: synth_pkg::THR_RST,
                  tol: synth_pkg::TOL_RST, amp_en: 1'b1, default: '0};
    end else begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // fs1 is a frequency select input in standalone and unused here
  assign freqsel1_lock_pin_o = st_reg.ld_pin;
  assign freqsel1_lock_pin_oe_o = st_reg.programmable_mode;
  assign ref_pulse_o = st_reg.ref_p;
  assign fb_pulse_o = st_reg.fb_p;
  assign rx_o = st_reg.mode[1];
  assign tx_o = st_reg.mode[2];
  assign programmable_mode_o = st_reg.programmable_mode;
  assign detector_polarity_o = st_reg.pol;
  assign pump_current_o = st_reg.pump;
  assign oscillator_current_o = st_reg.oscillator_current_setting;
  assign osc_startup_current_o = st_reg.osc_startup_current;
  assign osc_steady_current_o = st_reg.osc_steady_current;
  assign amp_reg_en_o = st_reg.amp_en;

  ////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  AST_PUM_ENTRY: assert property (
    st_reg.armed && !st_reg.programmable_mode && freqsel0_serial_enable_pin_i != st_reg.sden0 |=> freqsel1_lock_pin_oe_o)
    else $error("select pin change did not enter programmable mode");
  AST_REF_SPACING: assert property (
    ref_pulse_o && st_reg.mode == $past(st_reg.mode) |=> !ref_pulse_o [*3])
    else $error("reference pulses closer than four clocks");
  AST_MOD17_SWALLOW: assert property (
    st_reg.pre == synth_pkg::PRE_LAST17 |-> st_reg.a_cnt != 4'h0)
    else $error("prescaler ran to 17 outside swallow phase");
  AST_FB_END: assert property (
    fb_pulse_o |-> $past(st_reg.b_cnt <= 13'h0001 && vco_i))
    else $error("feedback pulse without program counter end");
  AST_FB_RELOAD: assert property (
    fb_pulse_o |-> st_reg.a_cnt == $past(n_sel[3:0])
                && st_reg.b_cnt == $past(n_sel[16:4]))
    else $error("feedback counters not reloaded from ratio");
  AST_QUAL_HOLD: assert property (
    !overlap && !unlock && !enter |=> $stable(st_reg.qual))
    else $error("qualify counter moved without overlap");
  AST_LOCK_SET: assert property (
    st_reg.qual == 8'h00 && !unlock && !enter && st_reg.mode == st_next.mode
    && (st_reg.mode == synth_pkg::M_RX || st_reg.mode == synth_pkg::M_TX)
    |=> st_reg.lock)
    else $error("lock not set at qualify count end");
  AST_UNLOCK_RELOAD: assert property (
    unlock && !enter |=> st_reg.qual == $past(st_reg.thr))
    else $error("unlock did not reload qualify counter");
  AST_WATCH_RELOAD: assert property (
    overlap |=> st_reg.watch == $past(st_reg.tol))
    else $error("watch counter not reloaded on overlap");
  AST_LATCHED: assert property (
    $fell(st_reg.lock) && !$past(st_reg.latch_sel)
    |-> $past(st_reg.mode) != $past(st_next.mode))
    else $error("latched lock dropped inside active mode");
  AST_ENTER_CLEAR: assert property (
    enter |=> !st_reg.lock && st_reg.watch == $past(st_reg.tol))
    else $error("mode entry did not clear lock");

  COV_LOCK: cover property ($rose(st_reg.lock));
  COV_UNLOCK: cover property ($fell(st_reg.lock) && st_reg.latch_sel);
  COV_FB: cover property (fb_pulse_o && st_reg.mode == synth_pkg::M_TX);
  COV_WRITE: cover property (st_reg.programmable_mode && $fell(freqsel0_serial_enable_pin_i)
                             && st_reg.bits == 5'(synth_pkg::FRAME_W));
endmodule : synth_core

/* far_model.sv */
// behavioural phase detector and vco pulse source facing the synthesizer core
// assumes the bench drives overlap_i just after a rising clock edge
`timescale 1ns/1ps
module far_model (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic overlap_i,
  output logic      vco_o,
  output logic      up_o,
  output logic      dn_o
);
  logic ph_reg;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ph_reg <= 1'b0;
    end else begin
      ph_reg <= ~ph_reg;
    end
  end
  // one vco pulse every second clock keeps the feedback period exact
  assign vco_o = ph_reg;
  // unbalanced case: up and down alternate and never meet
  assign up_o  = overlap_i | ph_reg;
  assign dn_o  = overlap_i | ~ph_reg;
endmodule : far_model

/* tb_top.sv */
// self-checking bench for the synthesizer core with a far-side pulse model
// assumes far_model and synth_pkg are compiled first
`timescale 1ns/1ps
module tb_top;
  logic        clk_i, rst_n_i, sclk, sdta, fs0, ovl;
  logic        vco, up, dn, ld, ld_oe, refp, fbp, rx, tx, pm, pol, amp;
  logic [1:0]  pump, vcoc;
  logic [3:0]  st, sd;
  logic [15:0] rv;
  int          err_count, check_count, cyc, seed, p, k, a, b;
  int          rl[4];
  synth_core dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .re_sclk_i(sclk), .te_sdta_i(sdta),
    .freqsel0_serial_enable_pin_i(fs0), .freqsel1_lock_pin_i(1'b0), .vco_i(vco), .up_i(up), .dn_i(dn), .freqsel1_lock_pin_o(ld),
    .freqsel1_lock_pin_oe_o(ld_oe), .ref_pulse_o(refp), .fb_pulse_o(fbp), .rx_o(rx), .tx_o(tx),
    .programmable_mode_o(pm), .detector_polarity_o(pol), .pump_current_o(pump),
    .oscillator_current_o(vcoc), .osc_startup_current_o(st), .osc_steady_current_o(sd),
    .amp_reg_en_o(amp));
  far_model far_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .overlap_i(ovl), .vco_o(vco),
    .up_o(up), .dn_o(dn));
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 90000) begin
      err_count++;
      conclude();
    end
  end
  task conclude;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : conclude
  task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    check_count++;
    if (e !== s) begin
      err_count++;
      $display("unexpected %s expected %0h seen %0h", nm, e, s);
    end
  endtask : chk
  ////////////////////////////////////////////////////////////////////////////////
  // one 24-bit frame, msb first, data held through each high clock phase
  task send(input logic [2:0] adr, input logic [20:0] d);
    logic [23:0] f;
    f = {adr, d};
    @(posedge clk_i) fs0 <= 1'b1;
    for (int i = 23; i >= 0; i--) begin
      @(posedge clk_i) begin
        sdta <= f[i];
        sclk <= 1'b0;
      end
      @(posedge clk_i) sclk <= 1'b1;
    end
    @(posedge clk_i) sclk <= 1'b0;
    @(posedge clk_i) fs0 <= 1'b0;
    repeat (3) @(posedge clk_i);
    @(negedge clk_i);
  endtask : send
  // cycles between two pulses; the second call sees the settled ratio
  task period(input bit fb, output int per);
    per = 0;
    for (k = 0; k < 8000; k++) begin
      @(negedge clk_i);
      if (fb ? fbp : refp) break;
    end
    for (k = 1; k < 8000; k++) begin
      @(negedge clk_i);
      if (fb ? fbp : refp) begin
        per = k;
        break;
      end
    end
  endtask : period
  function automatic logic [20:0] cfg(input int op, lt, pl, pu, vc, su, ss);
    return 21'(op | lt << synth_pkg::F_LATCH | pl << synth_pkg::F_POL | pu << synth_pkg::F_PUMP
      | vc << synth_pkg::F_VCO | su << synth_pkg::F_OSC_STARTUP_CURRENT | ss << synth_pkg::F_OSC_STEADY_CURRENT);
  endfunction : cfg
  function automatic int ref_x(input int r);
    return (r < 4) ? 4 : r;
  endfunction : ref_x
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    seed = 24;
    err_count = 0;
    check_count = 0;
    cyc = 0;
    rst_n_i = 1'b0;
    sclk = 1'b1;
    sdta = 1'b0;
    fs0 = 1'b0;
    ovl = 1'b0;
    repeat (16) @(posedge clk_i);
    @(negedge clk_i);
    chk("reset settings", {2'b0, synth_pkg::PUMP_RST, synth_pkg::VCO_RST, synth_pkg::OSC_STARTUP_CURRENT_RST,
      synth_pkg::OSC_STEADY_CURRENT_RST, 1'b1}, {pm, ld_oe, pump, vcoc, st, sd, amp});
    @(posedge clk_i) rst_n_i <= 1'b1;
    repeat (4) @(negedge clk_i);
    chk("standalone mode", 3'b010, {pm, rx, tx});
    period(0, p);
    period(0, p);
    chk("preset ref period", ref_x(synth_pkg::RX_REF_RST), p);
    $display("test standalone done");
    // polarity 0 and lowest oscillator current, equal limits
    send(synth_pkg::A_CFG, cfg(1, 1, 0, 0, 0, 5, 5));
    chk("programmable", 4'b1110, {pm, ld_oe, rx, amp});
    repeat (4) begin
      rv = 16'($random(seed));
      send(synth_pkg::A_CFG, cfg(1, 1, rv[0], rv[2:1], rv[4:3], rv[8:5], rv[12:9]));
      chk("settings", {rv[0], rv[2:1], rv[4:3], rv[8:5], rv[12:9], rv[8:5] != rv[12:9]},
        {pol, pump, vcoc, st, sd, amp});
    end
    $display("test settings done");
    rl = '{3, 4, 1023, 8 + ($random(seed) & 255)};
    foreach (rl[i]) begin
      send(synth_pkg::A_RX_REF, 21'(rl[i]));
      period(0, p);
      period(0, p);
      chk("ref period", ref_x(rl[i]), p);
    end
    $display("test reference divider done");
    for (int i = 0; i < 3; i++) begin
      rv = 16'($random(seed));
      a = (i == 0) ? 0 : rv[3:0];
      b = (i == 0) ? 4 : 16 + rv[9:5];
      send(synth_pkg::A_RX_FB, 21'({13'(b), 4'(a)}));
      period(1, p);
      period(1, p);
      chk("fb period", 2 * (17 * a + 16 * (b - a)), p);
    end
    $display("test feedback divider done");
    send(synth_pkg::A_TX_REF, 21'(7));
    send(synth_pkg::A_CFG, cfg(2, 1, 0, 3, 1, 12, 4));
    period(0, p);
    period(0, p);
    chk("tx ref period", {rx, tx, 30'(p)}, {2'b01, 30'(7)});
    send(synth_pkg::A_CFG, cfg(3, 1, 0, 3, 1, 12, 4));
    period(0, p);
    period(0, p);
    chk("idle ref period", {rx, tx, 30'(p)}, {2'b00, 30'(7)});
    $display("test modes done");
    send(synth_pkg::A_LOCK, {5'h0, 8'd4, 8'd6});
    for (int lt = 1; lt >= 0; lt--) begin
      @(posedge clk_i) ovl <= 1'b0;
      send(synth_pkg::A_CFG, cfg(0, lt, 0, 3, 1, 12, 4));
      chk("lock off", 1'b0, ld);
      @(posedge clk_i) ovl <= 1'b1;
      send(synth_pkg::A_CFG, cfg(1, lt, 0, 3, 1, 12, 4));
      for (k = 0; k < 40 && ld !== 1'b1; k++) @(negedge clk_i);
      chk("lock", 1'b1, ld);
      @(posedge clk_i) ovl <= 1'b0;
      repeat (20) @(negedge clk_i);
      chk("lock after loss", (lt == 0) ? 1'b1 : 1'b0, ld);
    end
    $display("test lock detector done");
    conclude();
  end
endmodule : tb_top
